// ### verilog/dscp_pkg.sv
/*
  Shared constants for the DAC serial configuration port: instruction byte
  layout, transfer sizes and serial clock timing.
  Assumes a 100 MHz system clock on both ends of the link.
*/
package dscp_pkg;

  // ==========================================================================
  // Instruction byte layout
  // ==========================================================================
  localparam int unsigned INSTR_BITS = 8;
  localparam int unsigned READ_BIT   = 7;
  localparam int unsigned CNT_HI_BIT = 6;
  localparam int unsigned CNT_LO_BIT = 5;
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned CNT_W      = 2;
  localparam int unsigned MAX_BYTES  = 4;
  localparam int unsigned NUM_REGS   = 32;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]        REG_RESET  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SCLK_MAX_MHZ    = 20;
  localparam int unsigned SCLK_MIN_HALF_NS = 1000 / (2 * SCLK_MAX_MHZ);
  localparam int unsigned SCLK_MIN_HALF_CYC =
    (SCLK_MIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Half period used by the master; long enough for both two-stage samplers.
  localparam int unsigned SCLK_HALF_CYC = 8;

endpackage

// ### verilog/dscp_if.sv
/*
  Link between the serial master and the configuration port: serial clock,
  active-low chip select, mode-select/reset and one shared data line.
  Assumes only one end enables its data driver at a time.
*/
`timescale 1ns/1ps
interface dscp_if;
  logic sclk;
  logic chip_select_n;
  logic mode_reset;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic sdio_in;

  // Resolved data line level; a pull-up holds it high when nobody drives.
  assign sdio_in = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);

  modport dev  (input sclk, input chip_select_n, input mode_reset, input sdio_in,
                output dev_sdio_o, output dev_sdio_oe);
  modport host (output sclk, output chip_select_n, output mode_reset, input sdio_in,
                output host_sdio_o, output host_sdio_oe);
endinterface

// ### verilog/dscp_device.sv
/*
  Device end of the serial configuration port with its register array.
  Assumes the link pins come from another clock domain and a master that
  keeps chip select low for a whole cycle.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - cycle is instruction phase then data phase
// - instruction byte on first eight rising edges
// - decode direction, byte count, start address
// - reset pin pulse restarts instruction phase
// - reset mid-cycle discards bits, no write
// - data phase carries one to four bytes
// - register updates at each byte's last bit
// - single/multibyte, MSB-first or LSB-first order
// - one shared pin carries both directions
// - every register readable and writable
// - master should prefer multibyte cycles
// - bit7 read, bits6-5 count, bits4-0 address
// - count 00..11 means one..four bytes
// - sample on rise, drive on fall, 20 MHz
// - chip select low whole cycle; else float
module dscp_device
  import dscp_pkg::*;
#(
  parameter int unsigned REGS = NUM_REGS
)
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  dscp_if.dev                         link,
  input  wire logic                   lsb_first,
  input  wire logic [ADDR_W-1:0]      user_rd_addr,
  output logic      [7:0]             user_rd_data,
  output logic                        wr_strobe,
  output logic      [ADDR_W-1:0]      wr_addr,
  output logic      [7:0]             wr_data
);
  import dscp_pkg::*;

  typedef enum logic [3:0] {
    D_IDLE  = 4'b0001,
    D_INSTR = 4'b0010,
    D_DATA  = 4'b0100,
    D_DONE  = 4'b1000
  } dscp_dstate_t;

  // ==========================================================================
  // Shift helper
  // ==========================================================================
  // Shifts one bit into a byte in the order chosen by lsb_first.
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsbf);
    shift_in = lsbf ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  // ==========================================================================
  // Pin samplers
  // ==========================================================================
  logic sclk_s1;
  logic sclk_s2;
  logic sclk_s3;
  logic csn_s1;
  logic csn_s2;
  logic sdi_s1;
  logic sdi_s2;
  logic mrst_s1;
  logic mrst_s2;
  logic mrst_s3;

  // Two flops per pin; a third stage on clocks and reset pin finds edges.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      csn_s1  <= 1'b1;
      csn_s2  <= 1'b1;
      sdi_s1  <= 1'b1;
      sdi_s2  <= 1'b1;
      mrst_s1 <= 1'b0;
      mrst_s2 <= 1'b0;
      mrst_s3 <= 1'b0;
    end
    else
    begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      csn_s1  <= link.chip_select_n;
      csn_s2  <= csn_s1;
      sdi_s1  <= link.sdio_in;
      sdi_s2  <= sdi_s1;
      mrst_s1 <= link.mode_reset;
      mrst_s2 <= mrst_s1;
      mrst_s3 <= mrst_s2;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic mrst_fall;

  // Edge strobes, one system clock wide.
  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;
  assign mrst_fall = ~mrst_s2 & mrst_s3;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  dscp_dstate_t      state;
  dscp_dstate_t      next_state;
  logic [2:0]        bit_cnt;
  logic [2:0]        next_bit_cnt;
  logic [CNT_W-1:0]  byte_cnt;
  logic [CNT_W-1:0]  next_byte_cnt;
  logic [CNT_W-1:0]  xfer_cnt;
  logic [CNT_W-1:0]  next_xfer_cnt;
  logic              is_read;
  logic              next_is_read;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [7:0]        rx_sh;
  logic [7:0]        next_rx_sh;
  logic [7:0]        tx_byte;
  logic [7:0]        next_tx_byte;
  logic              sdo;
  logic              next_sdo;
  logic              sdo_en;
  logic              next_sdo_en;
  logic              next_wr_strobe;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [7:0]        next_wr_data;
  logic [7:0]        byte_in;
  logic [ADDR_W-1:0] step_addr;
  logic [7:0]        regs [REGS];

  assign byte_in   = shift_in(rx_sh, sdi_s2, lsb_first);
  assign step_addr = lsb_first ? addr + 5'h01 : addr - 5'h01;

  // Next-state logic for the serial sequencer and its outputs.
  always_comb
  begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_byte_cnt  = byte_cnt;
    next_xfer_cnt  = xfer_cnt;
    next_is_read   = is_read;
    next_addr      = addr;
    next_rx_sh     = rx_sh;
    next_tx_byte   = tx_byte;
    next_sdo       = sdo;
    next_sdo_en    = sdo_en;
    next_wr_strobe = 1'b0;
    next_wr_addr   = wr_addr;
    next_wr_data   = wr_data;
    if (mrst_s2 || mrst_fall)
    begin
      // Pending bits are dropped and no write is issued.
      next_state   = csn_s2 ? D_IDLE : D_INSTR;
      next_bit_cnt = 3'd0;
      next_sdo_en  = 1'b0;
    end
    else if (csn_s2)
    begin
      next_state   = D_IDLE;
      next_bit_cnt = 3'd0;
      next_sdo_en  = 1'b0;
    end
    else
    begin
      unique case (state)
        D_IDLE:
        begin
          next_state   = D_INSTR;
          next_bit_cnt = 3'd0;
        end
        D_INSTR:
        begin
          if (sclk_rise)
          begin
            next_rx_sh   = byte_in;
            next_bit_cnt = bit_cnt + 3'd1;
            if (bit_cnt == 3'd7)
            begin
              next_is_read  = byte_in[READ_BIT];
              next_xfer_cnt = {byte_in[CNT_HI_BIT], byte_in[CNT_LO_BIT]};
              next_addr     = byte_in[ADDR_W-1:0];
              next_tx_byte  = regs[byte_in[ADDR_W-1:0]];
              next_byte_cnt = '0;
              next_state    = D_DATA;
            end
          end
        end
        D_DATA:
        begin
          if (is_read && sclk_fall)
          begin
            // Data and pin enable go out on a fall, after the master has let go.
            next_sdo_en = 1'b1;
            next_sdo    = lsb_first ? tx_byte[bit_cnt] : tx_byte[3'd7 - bit_cnt];
          end
          if (sclk_rise)
          begin
            next_rx_sh   = byte_in;
            next_bit_cnt = bit_cnt + 3'd1;
            if (bit_cnt == 3'd7)
            begin
              if (!is_read)
              begin
                next_wr_strobe = 1'b1;
                next_wr_addr   = addr;
                next_wr_data   = byte_in;
              end
              next_addr     = step_addr;
              next_tx_byte  = regs[step_addr];
              next_byte_cnt = byte_cnt + 2'd1;
              if (byte_cnt == xfer_cnt)
              begin
                next_state  = D_DONE;
                next_sdo_en = 1'b0;
              end
            end
          end
        end
        D_DONE:
        begin
          next_sdo_en = 1'b0;
        end
      endcase
    end
  end

  // Registers of the sequencer and the register array.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state        <= D_IDLE;
      bit_cnt      <= 3'd0;
      byte_cnt     <= '0;
      xfer_cnt     <= '0;
      is_read      <= 1'b0;
      addr         <= ADDR_RESET;
      rx_sh        <= REG_RESET;
      tx_byte      <= REG_RESET;
      sdo          <= 1'b0;
      sdo_en       <= 1'b0;
      wr_strobe    <= 1'b0;
      wr_addr      <= ADDR_RESET;
      wr_data      <= REG_RESET;
      user_rd_data <= REG_RESET;
      for (int i = 0; i < REGS; i++)
      begin
        regs[i] <= REG_RESET;
      end
    end
    else
    begin
      state        <= next_state;
      bit_cnt      <= next_bit_cnt;
      byte_cnt     <= next_byte_cnt;
      xfer_cnt     <= next_xfer_cnt;
      is_read      <= next_is_read;
      addr         <= next_addr;
      rx_sh        <= next_rx_sh;
      tx_byte      <= next_tx_byte;
      sdo          <= next_sdo;
      sdo_en       <= next_sdo_en;
      wr_strobe    <= next_wr_strobe;
      wr_addr      <= next_wr_addr;
      wr_data      <= next_wr_data;
      user_rd_data <= regs[user_rd_addr];
      if (next_wr_strobe)
      begin
        regs[next_wr_addr] <= next_wr_data;
      end
    end
  end

  // Link outputs straight from flops.
  assign link.dev_sdio_o  = sdo;
  assign link.dev_sdio_oe = sdo_en;

endmodule

// ### verilog/dscp_host.sv
/*
  Master end of the serial configuration port: builds the serial clock by a
  divider, shifts out the instruction and write data and collects read data.
  Assumes a device that drives read data only in the data phase of a read.
*/
`timescale 1ns/1ps
module dscp_host
  import dscp_pkg::*;
#(
  parameter int unsigned SCLK_HALF = SCLK_HALF_CYC
)
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  dscp_if.host                        link,
  input  wire logic                   start,
  input  wire logic                   pulse_reset,
  input  wire logic                   cmd_read,
  input  wire logic [CNT_W-1:0]       cmd_count,
  input  wire logic [ADDR_W-1:0]      cmd_addr,
  input  wire logic [31:0]            cmd_wdata,
  input  wire logic                   lsb_first,
  output logic                        busy,
  output logic                        done,
  output logic      [31:0]            rd_data
);
  import dscp_pkg::*;

  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_LO    = 5'b00010,
    H_HI    = 5'b00100,
    H_TAIL  = 5'b01000,
    H_PULSE = 5'b10000
  } dscp_hstate_t;

  // ==========================================================================
  // Read data sampler
  // ==========================================================================
  logic sdi_s1;
  logic sdi_s2;

  // Two flops before the data line is used.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sdi_s1 <= 1'b1;
      sdi_s2 <= 1'b1;
    end
    else
    begin
      sdi_s1 <= link.sdio_in;
      sdi_s2 <= sdi_s1;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  dscp_hstate_t state;
  dscp_hstate_t next_state;
  logic [7:0]   div;
  logic [7:0]   next_div;
  logic [5:0]   bit_idx;
  logic [5:0]   next_bit_idx;
  logic [7:0]   instr;
  logic [7:0]   next_instr;
  logic [31:0]  wbuf;
  logic [31:0]  next_wbuf;
  logic         lsbf;
  logic         next_lsbf;
  logic         sclk;
  logic         next_sclk;
  logic         csn;
  logic         next_csn;
  logic         mrst;
  logic         next_mrst;
  logic         sdo;
  logic         next_sdo;
  logic         sdo_en;
  logic         next_sdo_en;
  logic         next_busy;
  logic         next_done;
  logic [31:0]  next_rd_data;
  logic         tick;
  logic [5:0]   last_idx;
  logic [2:0]   pos;
  logic [1:0]   dbyte;

  assign tick     = (div == 8'(SCLK_HALF - 1));
  assign last_idx = {3'(instr[CNT_HI_BIT:CNT_LO_BIT] + 3'd1), 3'b111};
  assign pos      = lsbf ? bit_idx[2:0] : 3'd7 - bit_idx[2:0];
  assign dbyte    = 2'(bit_idx[5:3] - 3'd1);

  // Next-state logic: divider, bit sequencing and data capture.
  always_comb
  begin
    next_state   = state;
    next_div     = tick ? 8'd0 : div + 8'd1;
    next_bit_idx = bit_idx;
    next_instr   = instr;
    next_wbuf    = wbuf;
    next_lsbf    = lsbf;
    next_sclk    = sclk;
    next_csn     = csn;
    next_mrst    = mrst;
    next_sdo     = sdo;
    next_sdo_en  = sdo_en;
    next_busy    = busy;
    next_done    = 1'b0;
    next_rd_data = rd_data;
    unique case (state)
      H_IDLE:
      begin
        next_div = 8'd0;
        if (pulse_reset)
        begin
          next_mrst  = 1'b1;
          next_busy  = 1'b1;
          next_state = H_PULSE;
        end
        else if (start)
        begin
          next_instr   = {cmd_read, cmd_count, cmd_addr};
          next_wbuf    = cmd_wdata;
          next_lsbf    = lsb_first;
          next_bit_idx = 6'd0;
          next_csn     = 1'b0;
          next_sdo     = lsb_first ? cmd_addr[0] : cmd_read;
          next_sdo_en  = 1'b1;
          next_busy    = 1'b1;
          next_state   = H_LO;
        end
      end
      H_LO:
      begin
        if (tick)
        begin
          next_sclk = 1'b1;
          if (instr[READ_BIT] && bit_idx[5:3] != 3'd0)
          begin
            next_rd_data[{dbyte, pos}] = sdi_s2;
          end
          next_state = H_HI;
        end
      end
      H_HI:
      begin
        if (tick)
        begin
          next_sclk    = 1'b0;
          next_bit_idx = bit_idx + 6'd1;
          if (bit_idx == last_idx)
          begin
            next_sdo_en = 1'b0;
            next_state  = H_TAIL;
          end
          else
          begin
            next_state  = H_LO;
            next_sdo_en = (bit_idx < 6'd7) || !instr[READ_BIT];
            if (bit_idx < 6'd7)
            begin
              next_sdo = lsbf ? instr[3'(bit_idx[2:0] + 3'd1)] : instr[3'(3'd6 - bit_idx[2:0])];
            end
            else
            begin
              next_sdo = wbuf[{2'(next_bit_idx[5:3] - 3'd1),
                               lsbf ? next_bit_idx[2:0] : 3'd7 - next_bit_idx[2:0]}];
            end
          end
        end
      end
      H_TAIL:
      begin
        if (tick)
        begin
          next_csn   = 1'b1;
          next_busy  = 1'b0;
          next_done  = 1'b1;
          next_state = H_IDLE;
        end
      end
      H_PULSE:
      begin
        if (tick)
        begin
          next_mrst  = 1'b0;
          next_busy  = 1'b0;
          next_done  = 1'b1;
          next_state = H_IDLE;
        end
      end
    endcase
  end

  // Registers of the master sequencer.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state   <= H_IDLE;
      div     <= 8'd0;
      bit_idx <= 6'd0;
      instr   <= 8'h00;
      wbuf    <= 32'h0000_0000;
      lsbf    <= 1'b0;
      sclk    <= 1'b0;
      csn     <= 1'b1;
      mrst    <= 1'b0;
      sdo     <= 1'b0;
      sdo_en  <= 1'b0;
      busy    <= 1'b0;
      done    <= 1'b0;
      rd_data <= 32'h0000_0000;
    end
    else
    begin
      state   <= next_state;
      div     <= next_div;
      bit_idx <= next_bit_idx;
      instr   <= next_instr;
      wbuf    <= next_wbuf;
      lsbf    <= next_lsbf;
      sclk    <= next_sclk;
      csn     <= next_csn;
      mrst    <= next_mrst;
      sdo     <= next_sdo;
      sdo_en  <= next_sdo_en;
      busy    <= next_busy;
      done    <= next_done;
      rd_data <= next_rd_data;
    end
  end

  // Link outputs straight from flops.
  assign link.sclk          = sclk;
  assign link.chip_select_n = csn;
  assign link.mode_reset    = mrst;
  assign link.host_sdio_o   = sdo;
  assign link.host_sdio_oe  = sdo_en;

endmodule

// ### testbench/dscp_chk.sv
/*
  Link checker: watches the serial link between the host and device ends.
  Assumes the host divider of 8 clock cycles for each serial clock half.
*/
`timescale 1ns/1ps
module dscp_chk
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic mode_reset,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe
);
  logic       sclk_q;
  logic [5:0] rises;
  logic [5:0] next_rises;

  // ====================
  // Frame bookkeeping
  // Counts serial clock rises while the device is selected.
  always_comb
  begin
    next_rises = rises;
    if (sys_rst || chip_select_n)
      next_rises = 6'h00;
    else if (sclk && !sclk_q)
      next_rises = rises + 6'h01;
  end

  // Registers the edge detector and the rise count.
  always_ff @(posedge clk)
  begin
    sclk_q <= sclk;
    rises  <= next_rises;
  end

  // ====================
  // Link assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_float_idle: assert property (chip_select_n [*4] |-> !dev_sdio_oe)
    else $error("data pin driven while deselected");
  a_sclk_idle: assert property (chip_select_n |-> !sclk)
    else $error("serial clock moves outside a frame");
  a_sclk_half: assert property ($changed(sclk) |=> $stable(sclk) [*7])
    else $error("serial clock half period too short");
  a_frame_length: assert property ($rose(chip_select_n) |-> rises inside {6'h10, 6'h18, 6'h20, 6'h28})
    else $error("frame length is not one to four bytes");
  a_drive_phase: assert property (dev_sdio_oe && !chip_select_n |-> rises >= 6'h08)
    else $error("device drives during the instruction");
  a_dev_bit_edge: assert property ($changed(dev_sdio_o) && dev_sdio_oe && $past(dev_sdio_oe) |-> !sclk)
    else $error("read bit changed while serial clock high");
  a_host_bit_edge: assert property ($changed(host_sdio_o) && host_sdio_oe && $past(host_sdio_oe) |-> !sclk)
    else $error("write bit changed while serial clock high");
  a_reset_width: assert property ($rose(mode_reset) |-> mode_reset [*8] ##1 !mode_reset)
    else $error("reset pin pulse has the wrong width");
  a_one_driver: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data line");
endmodule

// ### testbench/testbench.sv
/*
  Top bench: host and device joined by one link, plus a second device on a
  link driven by the bench to pulse the reset pin in mid-frame.
  Assumes a 100 MHz clock and the default host divider.
*/
`timescale 1ns/1ps
module testbench;
  import dscp_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        start = 1'b0;
  logic        pulse_reset = 1'b0;
  logic        cmd_read = 1'b0;
  logic [1:0]  cmd_count = 2'h0;
  logic [4:0]  cmd_addr = 5'h00;
  logic [31:0] cmd_wdata = 32'h0000_0000;
  logic        lsb = 1'b0;
  logic [4:0]  rd_addr = 5'h00;
  logic        busy, done, wr_strobe, wr_strobe_b;
  logic [31:0] rd_data;
  logic [7:0]  user_rd_data, wr_data, wr_data_b, ibits;
  logic [4:0]  wr_addr, wr_addr_b;
  logic [7:0]  model [32];
  logic [4:0]  exp_a [4];
  logic [7:0]  exp_d [4];
  logic [31:0] seed = 32'h0000_fee4;
  int          errors = 0;
  int          n_tests = 0;
  int          scnt = 0;
  int          scnt_b = 0;
  int          rise_n = 0;
  dscp_if link ();
  dscp_if link_b ();

  // Makes the 100 MHz clock.
  always #5 clk = ~clk;

  dscp_host i_dscp_host (.clk(clk), .sys_rst(sys_rst), .link(link.host), .start(start), .pulse_reset(pulse_reset),
    .cmd_read(cmd_read), .cmd_count(cmd_count), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .lsb_first(lsb),
    .busy(busy), .done(done), .rd_data(rd_data));
  dscp_device i_dscp_device (.clk(clk), .sys_rst(sys_rst), .link(link.dev), .lsb_first(lsb), .user_rd_addr(rd_addr),
    .user_rd_data(user_rd_data), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));
  dscp_device i_dscp_device_b (.clk(clk), .sys_rst(sys_rst), .link(link_b.dev), .lsb_first(1'b0),
    .user_rd_addr(rd_addr), .user_rd_data(), .wr_strobe(wr_strobe_b), .wr_addr(wr_addr_b), .wr_data(wr_data_b));
  dscp_chk i_dscp_chk (.clk(clk), .sys_rst(sys_rst), .sclk(link.sclk), .chip_select_n(link.chip_select_n),
    .mode_reset(link.mode_reset), .host_sdio_o(link.host_sdio_o), .host_sdio_oe(link.host_sdio_oe),
    .dev_sdio_o(link.dev_sdio_o), .dev_sdio_oe(link.dev_sdio_oe));

  // ====================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Address of byte k: up when LSB first, down when MSB first, 5-bit wrap.
  function automatic logic [4:0] step(input logic [4:0] a, input int k, input logic l);
    return l ? a + 5'(k) : a - 5'(k);
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_addr(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t address %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      errors++;
      $display("[ERR] %0t count %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Checks every landed write against the expected address and byte.
  always @(posedge clk)
  begin
    if (wr_strobe === 1'b1)
    begin
      chk_addr(wr_addr, exp_a[scnt & 3]);
      chk_byte(wr_data, exp_d[scnt & 3]);
      scnt++;
    end
    if (wr_strobe_b === 1'b1)
    begin
      chk_byte(wr_data_b, 8'h5a);
      chk_addr(wr_addr_b, 5'h03);
      scnt_b++;
    end
  end

  // Collects the first eight bits seen on the wire in each frame.
  always @(negedge link.chip_select_n)
    rise_n = 0;
  always @(posedge link.sclk)
  begin
    if (rise_n < 8)
      ibits = {ibits[6:0], link.sdio_in};
    rise_n++;
  end

  task automatic wait_done();
    int i;
    for (i = 0; i < 800; i++)
    begin
      @(posedge clk);
      #1;
      if (done === 1'b1)
        break;
    end
    chk_cnt(int'(i < 800), 1);
  endtask

  // One host transfer; a held start with a new address while busy must be ignored.
  task automatic xfer(input logic rd, input logic [1:0] cnt, input logic [4:0] a, input logic [31:0] d,
                      input logic l);
    int k;
    logic [7:0] ins;
    logic [7:0] r;
    ins = {rd, cnt, a};
    for (k = 0; k < 8; k++)
      r[k] = ins[7 - k];
    for (k = 0; k < 4; k++)
    begin
      exp_a[k] = step(a, k, l);
      exp_d[k] = d[8*k+:8];
    end
    scnt = 0;
    @(posedge clk);
    cmd_read <= rd;
    cmd_count <= cnt;
    cmd_addr <= a;
    cmd_wdata <= d;
    lsb <= l;
    start <= 1'b1;
    @(posedge clk);
    cmd_addr <= ~a;
    repeat (2) @(posedge clk);
    chk_cnt(int'(busy === 1'b1), 1);
    start <= 1'b0;
    wait_done();
    chk_cnt(int'(busy === 1'b1), 0);
    chk_byte(ibits, l ? r : ins);
    chk_cnt(scnt, rd ? 0 : cnt + 1);
    for (k = 0; k <= cnt; k++)
      if (rd)
        chk_byte(rd_data[8*k+:8], model[exp_a[k]]);
      else
        model[exp_a[k]] = exp_d[k];
    @(posedge clk);
    rd_addr <= exp_a[cnt];
    repeat (2) @(posedge clk);
    #1;
    chk_byte(user_rd_data, model[exp_a[cnt]]);
  endtask

  // One serial bit on the bench link, MSB-first device, 160 ns period.
  task automatic bit_b(input logic b);
    link_b.host_sdio_o <= b;
    repeat (8) @(posedge clk);
    link_b.sclk <= 1'b1;
    repeat (8) @(posedge clk);
    link_b.sclk <= 1'b0;
  endtask

  // Sends the top bits of v; then pulses the reset pin with select kept low, or closes the frame.
  task automatic frame_b(input int nbits, input logic [15:0] v, input logic pulse);
    int i;
    link_b.chip_select_n <= 1'b0;
    link_b.host_sdio_oe <= 1'b1;
    for (i = 15; i > 15 - nbits; i--)
      bit_b(v[i]);
    link_b.mode_reset <= pulse;
    repeat (8) @(posedge clk);
    link_b.mode_reset <= 1'b0;
    link_b.chip_select_n <= !pulse;
    link_b.host_sdio_oe <= pulse;
    repeat (8) @(posedge clk);
  endtask

  // ====================
  // Main sequence
  initial
  begin
    int n;
    logic [31:0] wd;
    foreach (model[i])
      model[i] = 8'h00;
    link_b.sclk = 1'b0;
    link_b.chip_select_n = 1'b1;
    link_b.mode_reset = 1'b0;
    link_b.host_sdio_o = 1'b1;
    link_b.host_sdio_oe = 1'b0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(1'b1, 2'h3, 5'h1f, 32'h0000_0000, 1'b0);
    xfer(1'b0, 2'h3, 5'h01, 32'h1122_3344, 1'b0);
    xfer(1'b0, 2'h3, 5'h1e, 32'h5566_7788, 1'b1);
    xfer(1'b1, 2'h3, 5'h1f, 32'h0000_0000, 1'b1);
    xfer(1'b1, 2'h2, 5'h02, 32'h0000_0000, 1'b0);
    for (n = 0; n < 14; n++)
    begin
      seed = lfsr(seed);
      wd = lfsr(seed);
      xfer(1'b0, seed[1:0], seed[6:2], wd, seed[7]);
      xfer(1'b1, seed[1:0], seed[6:2], 32'h0000_0000, seed[7]);
      seed = wd;
    end
    @(posedge clk);
    pulse_reset <= 1'b1;
    @(posedge clk);
    pulse_reset <= 1'b0;
    wait_done();
    xfer(1'b1, 2'h1, 5'h00, 32'h0000_0000, 1'b1);
    @(posedge clk);
    frame_b(12, 16'h03a5, 1'b1);
    chk_cnt(scnt_b, 0);
    frame_b(16, 16'h035a, 1'b0);
    frame_b(5, 16'h03ff, 1'b1);
    frame_b(16, 16'h035a, 1'b0);
    chk_cnt(scnt_b, 2);
    final_report();
  end

  // Cuts a hang short.
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule
